// *** verilog/pbk_pkg.sv ***
// Package for the parameter bank and command source block.
// Assumes one 50 MHz clock; shared by the bank logic, the panel model and the bench.
package pbk_pkg;
	localparam int          PBK_NUM_BANKS  = 5;
	localparam int          PBK_NUM_PARAMS = 16;
	localparam int          PBK_DATA_W     = 16;
	localparam int          PBK_ADDR_W     = 7;
	// Register word offsets (byte addresses).
	localparam logic [7:0]  PBK_OFF_CTRL   = 8'h00;
	localparam logic [7:0]  PBK_OFF_BANK   = 8'h04;
	localparam logic [7:0]  PBK_OFF_REQ    = 8'h08;
	localparam logic [7:0]  PBK_OFF_STAT   = 8'h0c;
	localparam logic [7:0]  PBK_OFF_PADDR  = 8'h10;
	localparam logic [7:0]  PBK_OFF_PDATA  = 8'h14;
	localparam logic [7:0]  PBK_OFF_LREF   = 8'h18;
	// Control register fields.
	localparam int          PBK_CTL_SRC    = 0;
	localparam int          PBK_CTL_HALT   = 1;
	localparam int          PBK_CTL_INCH   = 2;
	localparam int          PBK_CTL_REV    = 3;
	localparam int          PBK_CTL_BOTH   = 4;
	localparam int          PBK_CTL_RNG    = 5;
	localparam int          PBK_CTL_LCL    = 8;
	localparam int          PBK_CTL_LANG   = 12;
	// Bank register fields.
	localparam int          PBK_BNK_ACT    = 0;
	localparam int          PBK_BNK_EDIT   = 4;
	// Request register fields.
	localparam int          PBK_REQ_COPY   = 0;
	localparam int          PBK_REQ_XFER   = 4;
	localparam int          PBK_REQ_OK     = 8;
	// Codes.
	localparam logic [2:0]  PBK_BANK_FACT  = 3'h0;
	localparam logic [2:0]  PBK_BANK_TRACK = 3'h5;
	localparam logic [2:0]  PBK_COPY_NONE  = 3'h0;
	localparam logic [2:0]  PBK_COPY_ALL   = 3'h5;
	localparam logic [1:0]  PBK_XFER_NONE  = 2'h0;
	localparam logic [1:0]  PBK_XFER_UP    = 2'h1;
	localparam logic [1:0]  PBK_XFER_DN    = 2'h2;
	localparam logic [1:0]  PBK_XFER_DNRF  = 2'h3;
	localparam logic [2:0]  PBK_LCL_OPEN   = 3'h1;
	localparam logic [2:0]  PBK_LCL_P100   = 3'h3;
	localparam logic [2:0]  PBK_LCL_P4     = 3'h4;
	// Reset values, and the highest language code.
	localparam logic [2:0]  PBK_RST_ACT    = 3'h1;
	localparam logic [2:0]  PBK_RST_EDIT   = 3'h5;
	localparam logic [2:0]  PBK_RST_LANG   = 3'h0;
	localparam logic [2:0]  PBK_LANG_MAX   = 3'h5;
	// First and last parameter indices that depend on the power rating.
	localparam int          PBK_RATED_LO   = 8;
	localparam int          PBK_RATED_HI   = 11;
	typedef enum logic [2:0] {
		PBK_IDLE, PBK_CPY_RD, PBK_CPY_WR, PBK_XF_RD, PBK_XF_WR
	} pbk_state_t;
endpackage

// *** verilog/pbk_mem.sv ***
// Parameter store: one word per bank and parameter, registered read.
// Assumes a single clock; one read and one write port.
`timescale 1ns/100ps
`default_nettype none
module pbk_mem #(
	parameter int AW = 7,
	parameter int DW = 16
) (
	input  wire logic          clk_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [DW-1:0] rdata_o
);
	logic [DW-1:0] mem_reg [0:(1<<AW)-1];
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_reg[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_reg[raddr_i];
	end
endmodule
`default_nettype wire

// *** verilog/pbk_bank.sv ***
// Parameter bank, command source and panel key gating for a motor drive.
// Assumes a classic Wishbone master on clk_i and asynchronous pin inputs.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pbk_bank
	import pbk_pkg::*;
#(
	parameter logic [15:0] SW_VERSION = 16'h0001
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [7:0]            adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	input  wire logic                  serial_i,
	input  wire logic                  bank_lsb_pin_i,
	input  wire logic                  bank_msb_pin_i,
	input  wire logic                  running_i,
	input  wire logic                  stop_cmd_i,
	input  wire logic                  key_start_i,
	input  wire logic                  key_halt_i,
	input  wire logic                  key_inch_i,
	input  wire logic                  key_dir_i,
	input  wire logic                  panel_ver_ok_i,
	output logic                       run_cmd_o,
	output logic                       halt_o,
	output logic                       inch_o,
	output logic                       dir_toggle_o,
	output logic      [2:0]            live_bank_o,
	output logic      [2:0]            language_o,
	output logic                       busy_o,
	output logic                       xfer_stb_o,
	output logic                       xfer_dir_up_o,
	output logic      [PBK_ADDR_W-1:0] xfer_addr_o,
	output logic      [PBK_DATA_W-1:0] xfer_data_o,
	input  wire logic [PBK_DATA_W-1:0] panel_data_i,
	input  wire logic [15:0]           ref_min_i,
	input  wire logic [15:0]           ref_max_i
);
	typedef struct packed {
		logic [1:0]            s0, s1, s2;
		logic                  cmd_src;
		logic                  halt_en, inch_en, rev_en, both_dir, rng;
		logic [2:0]            lcl_ctl, lang, act_sel, edit_sel, copy_req;
		logic [1:0]            xfer_req;
		logic [PBK_ADDR_W-1:0] paddr;
		logic [15:0]           lref;
		logic                  ack;
		logic [31:0]           rdat;
		pbk_state_t            st;
		logic [2:0]            dst;
		logic [3:0]            idx;
		logic                  all;
		logic                  run_cmd, halt, inch, dir, busy, xstb, xup;
		logic [PBK_ADDR_W-1:0] xaddr;
		logic [PBK_DATA_W-1:0] xdata;
		logic [2:0]            live;
		logic                  rd_fact;
	} pbk_st_t;
	pbk_st_t q_reg, q_next;
	logic                  we_mem;
	logic [PBK_ADDR_W-1:0] waddr, raddr;
	logic [PBK_DATA_W-1:0] wdata, rdata, rdv;
	logic [2:0]            edit_bank;
	logic                  acc, wr;
	pbk_mem #(.AW(PBK_ADDR_W), .DW(PBK_DATA_W)) u_mem (
		.clk_i   (clk_i),
		.we_i    (we_mem),
		.waddr_i (waddr),
		.wdata_i (wdata),
		.raddr_i (raddr),
		.rdata_o (rdata)
	);
	// Bank address is bank*16 + parameter index.
	function automatic logic [PBK_ADDR_W-1:0] pa(logic [2:0] b, logic [3:0] i);
		pa = {b, i};
	endfunction
	always_comb begin
		q_next = q_reg;
		we_mem = 1'b0;
		waddr  = '0;
		wdata  = '0;
		raddr  = q_reg.paddr;
		acc    = cyc_i && stb_i && !q_reg.ack;
		wr     = acc && we_i && sel_i[0];
		// The factory bank is never written, so its reads are forced to
		// zero here rather than trusting uninitialised storage.
		rdv    = q_reg.rd_fact ? '0 : rdata;
		// Pins pass three flops before use; s2 is the settled level.
		q_next.s0 = {bank_msb_pin_i, bank_lsb_pin_i};
		q_next.s1 = q_reg.s0;
		q_next.s2 = q_reg.s1;
		// Multi-bank mode follows the pins, else the select code.
		if (q_reg.act_sel == PBK_BANK_TRACK) begin
			q_next.live = {1'b0, q_reg.s2} + 3'h1;
		end else begin
			q_next.live = q_reg.act_sel;
		end
		edit_bank = (q_reg.edit_sel == PBK_BANK_TRACK) ? q_reg.live
			: q_reg.edit_sel;
		// Stop always wins over the start key.
		q_next.run_cmd = !stop_cmd_i && (q_reg.run_cmd || key_start_i);
		q_next.halt = key_halt_i && q_reg.halt_en;
		q_next.inch = key_inch_i && q_reg.inch_en && !stop_cmd_i;
		q_next.dir = key_dir_i && q_reg.cmd_src && q_reg.rev_en
			&& q_reg.both_dir && (q_reg.lcl_ctl == PBK_LCL_OPEN
			|| q_reg.lcl_ctl == PBK_LCL_P100);
		q_next.ack = acc;
		q_next.xstb = 1'b0;
		if (acc) begin
			case (adr_i)
			PBK_OFF_CTRL: q_next.rdat = {16'h0, 1'b0, q_reg.lang,
				1'b0, q_reg.lcl_ctl, 2'b0, q_reg.rng, q_reg.both_dir,
				q_reg.rev_en, q_reg.inch_en, q_reg.halt_en, q_reg.cmd_src};
			PBK_OFF_BANK: q_next.rdat = {24'h0, 1'b0, q_reg.edit_sel,
				1'b0, q_reg.act_sel};
			PBK_OFF_REQ:  q_next.rdat = {26'h0, q_reg.xfer_req,
				1'b0, q_reg.copy_req};
			PBK_OFF_STAT: q_next.rdat = {24'h0, q_reg.busy, 2'b0,
				q_reg.live, edit_bank[1:0]};
			PBK_OFF_PADDR: q_next.rdat = {25'h0, q_reg.paddr};
			PBK_OFF_PDATA: q_next.rdat = {16'h0, rdv};
			PBK_OFF_LREF: q_next.rdat = {16'h0, q_reg.lref};
			default:      q_next.rdat = 32'h0;
			endcase
		end
		if (wr) begin
			case (adr_i)
			PBK_OFF_CTRL: begin
				q_next.cmd_src  = dat_i[PBK_CTL_SRC];
				q_next.halt_en  = dat_i[PBK_CTL_HALT];
				q_next.inch_en  = dat_i[PBK_CTL_INCH];
				q_next.rev_en   = dat_i[PBK_CTL_REV];
				q_next.both_dir = dat_i[PBK_CTL_BOTH];
				q_next.rng      = dat_i[PBK_CTL_RNG];
				q_next.lcl_ctl  = dat_i[PBK_CTL_LCL +: 3];
				if (dat_i[PBK_CTL_LANG +: 3] <= PBK_LANG_MAX) begin
					q_next.lang = dat_i[PBK_CTL_LANG +: 3];
				end
			end
			PBK_OFF_BANK: begin
				if (dat_i[PBK_BNK_ACT +: 3] <= PBK_BANK_TRACK) begin
					q_next.act_sel = dat_i[PBK_BNK_ACT +: 3];
				end
				if (dat_i[PBK_BNK_EDIT +: 3] <= PBK_BANK_TRACK) begin
					q_next.edit_sel = dat_i[PBK_BNK_EDIT +: 3];
				end
			end
			PBK_OFF_REQ: begin
				// Acknowledge bit launches the request.
				if (dat_i[PBK_REQ_OK] && q_reg.st == PBK_IDLE) begin
					q_next.copy_req = dat_i[PBK_REQ_COPY +: 3];
					q_next.xfer_req = dat_i[PBK_REQ_XFER +: 2];
				end
			end
			PBK_OFF_PADDR: q_next.paddr = {3'h0, dat_i[3:0]};
			PBK_OFF_PDATA: begin
				// Factory bank is read-only; writes hit the edit bank,
				// live bank included, with no commit step.
				if (edit_bank != PBK_BANK_FACT && q_reg.st == PBK_IDLE) begin
					we_mem = 1'b1;
					waddr  = pa(edit_bank, q_reg.paddr[3:0]);
					wdata  = dat_i[15:0];
				end
			end
			PBK_OFF_LREF: begin
				// Serial source and non-local mode are refused.
				if (!serial_i && q_reg.cmd_src && (q_reg.lcl_ctl
					== PBK_LCL_P100 || q_reg.lcl_ctl == PBK_LCL_P4)) begin
					if (q_reg.rng) begin
						q_next.lref = ($signed(dat_i[15:0]) >
							$signed(ref_max_i)) ? ref_max_i : dat_i[15:0];
					end else if (dat_i[15:0] < ref_min_i) begin
						q_next.lref = ref_min_i;
					end else if (dat_i[15:0] > ref_max_i) begin
						q_next.lref = ref_max_i;
					end else begin
						q_next.lref = dat_i[15:0];
					end
				end
			end
			default: ;
			endcase
		end
		if (q_reg.st == PBK_IDLE) begin
			q_next.idx = 4'h0;
			raddr = pa(edit_bank, q_reg.paddr[3:0]);
		end else begin
			raddr = pa(edit_bank, q_reg.idx);
		end
		case (q_reg.st)
		PBK_IDLE: begin
			q_next.busy = 1'b0;
			if (q_reg.copy_req != PBK_COPY_NONE) begin
				// Running refuses and clears the request.
				if (running_i || !stop_cmd_i
					|| q_reg.copy_req > PBK_COPY_ALL) begin
					q_next.copy_req = PBK_COPY_NONE;
				end else begin
					q_next.st   = PBK_CPY_RD;
					q_next.busy = 1'b1;
					q_next.all  = q_reg.copy_req == PBK_COPY_ALL;
					q_next.dst  = (q_reg.copy_req == PBK_COPY_ALL) ? 3'h1
						: q_reg.copy_req;
				end
			end else if (q_reg.xfer_req != PBK_XFER_NONE) begin
				if (running_i || (q_reg.xfer_req != PBK_XFER_UP
					&& !panel_ver_ok_i)) begin
					q_next.xfer_req = PBK_XFER_NONE;
				end else begin
					q_next.st   = PBK_XF_RD;
					q_next.busy = 1'b1;
					q_next.dst  = 3'h1;
				end
			end
		end
		PBK_CPY_RD: q_next.st = PBK_CPY_WR;
		PBK_CPY_WR: begin
			// Source bank is the edit bank.
			if (q_reg.dst != edit_bank) begin
				we_mem = 1'b1;
				waddr  = pa(q_reg.dst, q_reg.idx);
				wdata  = rdv;
			end
			q_next.st  = PBK_CPY_RD;
			q_next.idx = q_reg.idx + 4'h1;
			if (q_reg.idx == 4'(PBK_NUM_PARAMS - 1)) begin
				q_next.idx = 4'h0;
				if (q_reg.all && q_reg.dst != 3'(PBK_NUM_BANKS - 1)) begin
					q_next.dst = q_reg.dst + 3'h1;
				end else begin
					q_next.st       = PBK_IDLE;
					q_next.copy_req = PBK_COPY_NONE;
				end
			end
		end
		PBK_XF_RD: begin
			// Address goes out a cycle early, so the panel word and the
			// uploaded word both belong to the word being moved.
			raddr        = pa(q_reg.dst, q_reg.idx);
			q_next.xaddr = pa(q_reg.dst, q_reg.idx);
			q_next.st    = PBK_XF_WR;
		end
		PBK_XF_WR: begin
			// Walks all user banks; panel data feeds downloads.
			raddr = pa(q_reg.dst, q_reg.idx);
			q_next.xstb  = 1'b1;
			q_next.xup   = q_reg.xfer_req == PBK_XFER_UP;
			q_next.xaddr = pa(q_reg.dst, q_reg.idx);
			q_next.xdata = rdv;
			if (q_reg.xfer_req == PBK_XFER_DN || (q_reg.xfer_req ==
				PBK_XFER_DNRF && (q_reg.idx < 4'(PBK_RATED_LO)
				|| q_reg.idx > 4'(PBK_RATED_HI)))) begin
				we_mem = 1'b1;
				waddr  = pa(q_reg.dst, q_reg.idx);
				wdata  = panel_data_i;
			end
			q_next.st  = PBK_XF_RD;
			q_next.idx = q_reg.idx + 4'h1;
			if (q_reg.idx == 4'(PBK_NUM_PARAMS - 1)) begin
				q_next.idx = 4'h0;
				if (q_reg.dst != 3'(PBK_NUM_BANKS - 1)) begin
					q_next.dst = q_reg.dst + 3'h1;
				end else begin
					q_next.st       = PBK_IDLE;
					q_next.xfer_req = PBK_XFER_NONE;
				end
			end
		end
		default: q_next.st = PBK_IDLE;
		endcase
		q_next.rd_fact = raddr[6:4] == PBK_BANK_FACT;
		if (rst_i) begin
			q_next          = '0;
			q_next.act_sel  = PBK_RST_ACT;
			q_next.edit_sel = PBK_RST_EDIT;
			q_next.lang     = PBK_RST_LANG;
			q_next.live     = PBK_RST_ACT;
			q_next.st       = PBK_IDLE;
		end
	end
	always_ff @(posedge clk_i) begin
		q_reg <= q_next;
	end
	assign dat_o         = q_reg.rdat;
	assign ack_o         = q_reg.ack;
	assign run_cmd_o     = q_reg.run_cmd;
	assign halt_o        = q_reg.halt;
	assign inch_o        = q_reg.inch;
	assign dir_toggle_o  = q_reg.dir;
	assign live_bank_o   = q_reg.live;
	assign language_o    = q_reg.lang;
	assign busy_o        = q_reg.busy;
	assign xfer_stb_o    = q_reg.xstb;
	assign xfer_dir_up_o = q_reg.xup;
	assign xfer_addr_o   = q_reg.xaddr;
	assign xfer_data_o   = q_reg.xdata;
	a_stop_beats_start: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_cmd_i |=> !run_cmd_o) else $error("start beat stop");
	a_halt_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		halt_o |-> $past(q_reg.halt_en)) else $error("halt ungated");
	a_dir_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		dir_toggle_o |-> $past(q_reg.cmd_src) && $past(q_reg.rev_en))
		else $error("dir key ungated");
	a_lref_serial: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && adr_i == PBK_OFF_LREF && serial_i) |=> $stable(q_reg.lref))
		else $error("serial lref write taken");
	a_pin_bank: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_reg.act_sel == PBK_BANK_TRACK) |=> live_bank_o ==
		{1'b0, $past(q_reg.s2)} + 3'h1) else $error("pin bank wrong");
	a_copy_run: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_reg.st == PBK_IDLE && running_i && q_reg.copy_req != 3'h0)
		|=> q_reg.st == PBK_IDLE && q_reg.copy_req == 3'h0)
		else $error("copy while running");
	a_busy_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		(q_reg.st == PBK_CPY_WR) |-> busy_o) else $error("no busy");
	a_fact_ro: assert property (@(posedge clk_i) disable iff (rst_i)
		we_mem |-> waddr[6:4] != PBK_BANK_FACT)
		else $error("factory bank written");
	a_lang_range: assert property (@(posedge clk_i) disable iff (rst_i)
		language_o <= PBK_LANG_MAX) else $error("bad language");
endmodule
`default_nettype wire

// *** bench/pbk_panel_model.sv ***
// Behavioural detachable panel: keeps uploaded words, returns them on download.
// Assumes the drive strobes one word every second cycle, addressed as {bank, index}.
`timescale 1ns/100ps
`default_nettype none
module pbk_panel_model
	import pbk_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  stb_i,
	input  wire logic                  up_i,
	input  wire logic [PBK_ADDR_W-1:0] addr_i,
	input  wire logic [PBK_DATA_W-1:0] data_i,
	output logic      [PBK_DATA_W-1:0] data_o
);
	logic [PBK_DATA_W-1:0] mem [2**PBK_ADDR_W];
	initial begin
		for (int i = 0; i < 2**PBK_ADDR_W; i++) begin
			mem[i] = 16'h0000;
		end
	end
	// The panel always presents the word it holds for the named address.
	assign data_o = mem[addr_i];
	always @(posedge clk_i) begin
		if (stb_i && up_i) begin
			mem[addr_i] <= data_i;
		end
	end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the parameter bank block and the panel model.
// Assumes the design acks one cycle after a taken Wishbone request.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pbk_pkg::*;
	typedef struct {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic [2:0]  lb;
		logic [2:0]  lg;
	} pbk_row_t;
	logic        clk_i, rst_i, cyc, stb, we, serial, lsb, msb, running, stop;
	logic        ks, kh, ki, kd, ver_ok, ack, run_cmd, halt, inch, dirt, busy;
	logic        xstb, xup;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat, q, x;
	logic [2:0]  live, lang;
	logic [6:0]  xaddr;
	logic [15:0] xdata, pdata, rmin, rmax;
	int          n_fail, n_tests, nup;
	pbk_row_t    rows[6] = '{
		'{8'h00, 32'h0000_5000, 32'h0000_5000, 3'h1, 3'h5},
		'{8'h04, 32'h0000_0033, 32'h0000_0033, 3'h3, 3'h5},
		'{8'h04, 32'h0000_0050, 32'h0000_0050, 3'h0, 3'h5},
		'{8'h1c, 32'h0000_ffff, 32'h0000_0000, 3'h0, 3'h5},
		'{8'h00, 32'h0000_2000, 32'h0000_2000, 3'h0, 3'h2},
		'{8'h04, 32'h0000_0024, 32'h0000_0024, 3'h4, 3'h2}};
	logic [31:0] dc[5] = '{32'h119, 32'h219, 32'h319, 32'h109, 32'h118};
	logic        de[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	pbk_bank pbk_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
		.dat_o(rdat), .ack_o(ack), .serial_i(serial), .bank_lsb_pin_i(lsb),
		.bank_msb_pin_i(msb), .running_i(running), .stop_cmd_i(stop),
		.key_start_i(ks), .key_halt_i(kh), .key_inch_i(ki), .key_dir_i(kd),
		.panel_ver_ok_i(ver_ok), .run_cmd_o(run_cmd), .halt_o(halt),
		.inch_o(inch), .dir_toggle_o(dirt), .live_bank_o(live),
		.language_o(lang), .busy_o(busy), .xfer_stb_o(xstb),
		.xfer_dir_up_o(xup), .xfer_addr_o(xaddr), .xfer_data_o(xdata),
		.panel_data_i(pdata), .ref_min_i(rmin), .ref_max_i(rmax));
	pbk_panel_model pbk_panel_model_inst (.clk_i(clk_i), .stb_i(xstb),
		.up_i(xup), .addr_i(xaddr), .data_i(xdata), .data_o(pdata));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		if (xstb === 1'b1 && xup === 1'b1) begin
			nup++;
		end
	end
	task automatic give_verdict;
		$display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Read data is taken at the edge at which ack is seen high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (busy !== v && n < 2000) begin
			@(negedge clk_i);
			n++;
		end
		if (busy !== v) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task automatic run_req(input logic [31:0] r);
		wr(PBK_OFF_REQ, r);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rd(PBK_OFF_REQ);
		chk(q & 32'h37, 32'h0);
	endtask
	task automatic param(input logic [3:0] i, input logic [31:0] e);
		wr(PBK_OFF_PADDR, {28'h0, i});
		rd(PBK_OFF_PDATA);
		chk(q & 32'hffff, e);
	endtask
	initial begin
		{cyc, stb, we, serial, lsb, msb, running, ks, kh, ki, kd} = '0;
		{adr, sel, dat, n_fail, n_tests, nup} = '0;
		sel = 4'hf;
		stop = 1'b1;
		ver_ok = 1'b1;
		rmin = 16'h000a;
		rmax = 16'h0064;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(1);
		chk({29'h0, live}, 32'h1);
		chk({29'h0, lang}, 32'h0);
		chk({30'h0, busy, ack}, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk(q, rows[i].e);
			chk({26'h0, live, lang}, {26'h0, rows[i].lb, rows[i].lg});
		end
		for (int l = 0; l < 6; l++) begin
			wr(PBK_OFF_CTRL, 32'(l) << 12);
			chk({29'h0, lang}, 32'(l));
		end
		$display("registers done");
		wr(PBK_OFF_BANK, 32'h21);
		wr(PBK_OFF_PADDR, 32'h3);
		wr(PBK_OFF_PDATA, 32'hbeef);
		param(4'h3, 32'hbeef);
		wr(PBK_OFF_BANK, 32'h52);
		param(4'h3, 32'hbeef);
		$display("edit bank done");
		wr(PBK_OFF_BANK, 32'h01);
		param(4'h2, 32'h0);
		x = q & 32'hffff;
		wr(PBK_OFF_PDATA, ~x & 32'hffff);
		param(4'h2, x);
		wr(PBK_OFF_REQ, 32'h002);
		tick(4);
		chk({31'h0, busy}, 32'h0);
		run_req(32'h102);
		wr(PBK_OFF_BANK, 32'h21);
		param(4'h2, x);
		wr(PBK_OFF_PDATA, 32'h1357);
		run_req(32'h105);
		wr(PBK_OFF_BANK, 32'h41);
		param(4'h2, 32'h1357);
		running <= 1'b1;
		stop <= 1'b0;
		wr(PBK_OFF_PDATA, 32'h2468);
		wr(PBK_OFF_BANK, 32'h21);
		wr(PBK_OFF_REQ, 32'h104);
		tick(4);
		chk({31'h0, busy}, 32'h0);
		rd(PBK_OFF_REQ);
		chk(q & 32'h7, 32'h0);
		wr(PBK_OFF_BANK, 32'h41);
		param(4'h2, 32'h2468);
		$display("copy done");
		wr(PBK_OFF_BANK, 32'h55);
		for (int b = 0; b < 4; b++) begin
			@(posedge clk_i);
			{msb, lsb} <= 2'(b);
			for (int n = 0; n < 8 && live !== 3'(b + 1); n++) begin
				tick(1);
			end
			chk({29'h0, live}, 32'(b + 1));
		end
		rd(PBK_OFF_STAT);
		chk(q & 32'h3c, 32'h10);
		$display("bank pins done");
		{ks, kh, ki, kd} <= 4'hf;
		wr(PBK_OFF_CTRL, 32'h1);
		tick(3);
		chk({29'h0, halt, inch, dirt}, 32'h0);
		wr(PBK_OFF_CTRL, 32'h7);
		tick(3);
		chk({30'h0, halt, inch}, 32'h3);
		foreach (dc[i]) begin
			wr(PBK_OFF_CTRL, dc[i]);
			tick(3);
			chk({31'h0, dirt}, {31'h0, de[i]});
		end
		wr(PBK_OFF_CTRL, 32'h0);
		running <= 1'b0;
		stop <= 1'b1;
		tick(3);
		chk({31'h0, run_cmd}, 32'h0);
		@(posedge clk_i);
		{ks, kh, ki, kd} <= 4'h0;
		$display("keys done");
		wr(PBK_OFF_CTRL, 32'h301);
		wr(PBK_OFF_LREF, 32'h32);
		serial <= 1'b1;
		wr(PBK_OFF_LREF, 32'h3c);
		serial <= 1'b0;
		rd(PBK_OFF_LREF);
		chk(q & 32'hffff, 32'h32);
		wr(PBK_OFF_LREF, 32'hc8);
		rd(PBK_OFF_LREF);
		chk(q & 32'hffff, 32'h64);
		wr(PBK_OFF_CTRL, 32'h321);
		wr(PBK_OFF_LREF, 32'h5);
		rd(PBK_OFF_LREF);
		chk(q & 32'hffff, 32'h5);
		wr(PBK_OFF_LREF, 32'hc8);
		wr(PBK_OFF_CTRL, 32'h101);
		wr(PBK_OFF_LREF, 32'h46);
		wr(PBK_OFF_CTRL, 32'h400);
		wr(PBK_OFF_LREF, 32'h46);
		rd(PBK_OFF_LREF);
		chk(q & 32'hffff, 32'h64);
		$display("local reference done");
		wr(PBK_OFF_BANK, 32'h11);
		wr(PBK_OFF_PADDR, 32'h3);
		wr(PBK_OFF_PDATA, 32'h1111);
		wr(PBK_OFF_PADDR, 32'h9);
		wr(PBK_OFF_PDATA, 32'h2222);
		nup = 0;
		run_req(32'h110);
		chk(32'(nup), 32'h40);
		wr(PBK_OFF_PDATA, 32'hbbbb);
		param(4'h3, 32'h1111);
		wr(PBK_OFF_PDATA, 32'haaaa);
		// Rating-free download as used across power sizes.
		run_req(32'h130);
		param(4'h3, 32'h1111);
		param(4'h9, 32'hbbbb);
		run_req(32'h120);
		param(4'h9, 32'h2222);
		ver_ok <= 1'b0;
		wr(PBK_OFF_PDATA, 32'hcccc);
		wr(PBK_OFF_REQ, 32'h120);
		tick(4);
		chk({31'h0, busy}, 32'h0);
		param(4'h9, 32'hcccc);
		ver_ok <= 1'b1;
		running <= 1'b1;
		wr(PBK_OFF_REQ, 32'h110);
		tick(4);
		chk({31'h0, busy}, 32'h0);
		rd(PBK_OFF_REQ);
		chk(q & 32'h30, 32'h0);
		$display("panel transfer done");
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(1);
		chk({26'h0, live, lang}, 32'h8);
		$display("second reset done");
		give_verdict();
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire
